// >>> core/emu_pkg.sv
package emu_pkg;
   // Register indices and byte addresses (index times four)
   localparam logic [7:0] CFG_IDX = 8'h40;
   localparam logic [7:0] STIM_IDX = 8'h41;
   localparam logic [7:0] RESP_IDX = 8'h42;
   localparam logic [11:0] CFG_ADDR = {2'h0, CFG_IDX, 2'h0};
   localparam logic [11:0] STIM_ADDR = {2'h0, STIM_IDX, 2'h0};
   localparam logic [11:0] RESP_ADDR = {2'h0, RESP_IDX, 2'h0};
   // Field positions and masks
   localparam int CFG_TO_DIS_BIT = 5;
   localparam int CFG_FIRST_BIT = 2;
   localparam int CFG_RSVD_BIT = 1;
   localparam int CFG_DIS_BIT = 0;
   localparam int STIM_TYPE_BIT = 6;
   localparam logic [7:0] CFG_WMASK = 8'h3d;
   localparam logic [7:0] STIM_WMASK = 8'h7f;
   localparam logic [7:0] CFG_RST = 8'h01;
   localparam logic [6:0] STIM_RST = 7'h00;
   localparam logic [7:0] RESP_RST = 8'h00;
   localparam logic [3:0] MAG_RSVD = 4'hf;
   // Stimulus select codes
   localparam logic [2:0] STIM_VBUS_RDY = 3'h0;
   localparam logic [2:0] STIM_POS_HI = 3'h1;
   localparam logic [2:0] STIM_WINDOW = 3'h2;
   localparam logic [2:0] STIM_NEG_HI = 3'h3;
   localparam logic [2:0] STIM_POS_HI2 = 3'h6;
   localparam logic [2:0] STIM_VBUS_ON = 3'h7;
   // Response select codes
   localparam logic [3:0] RSP_REMOVE = 4'h0;
   localparam logic [3:0] RSP_V_POS = 4'h1;
   localparam logic [3:0] RSP_V_NEG = 4'h2;
   localparam logic [3:0] RSP_V_BOTH = 4'h3;
   localparam logic [3:0] RSP_R_POS = 4'h4;
   localparam logic [3:0] RSP_D_POS = 4'h6;
   localparam logic [3:0] RSP_R_NEG = 4'h7;
   localparam logic [3:0] RSP_D_NEG = 4'h9;
   localparam logic [3:0] RSP_BRIDGE = 4'ha;
   localparam logic [3:0] RSP_D_BOTH = 4'hc;
   localparam logic [3:0] RSP_R_BOTH = 4'hd;
   localparam logic [3:0] RSP_PD_A = 4'he;
   localparam logic [3:0] RSP_PD_B = 4'hf;
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_NS = 1000000;
   localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam logic [6:0] STIM_DELAY_MS [0:7] = '{7'h00, 7'h01, 7'h05, 7'h0a,
                                                  7'h14, 7'h28, 7'h50, 7'h64};
   // What a data line is connected to
   typedef enum logic [1:0] {
      LN_NONE = 2'b00,
      LN_VOLT = 2'b01,
      LN_RGND = 2'b10,
      LN_DIV = 2'b11
   } line_e;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT = 3'b001,
      ST_DELAY = 3'b010,
      ST_HOLD = 3'b011,
      ST_DONE = 3'b100,
      ST_PEND = 3'b101
   } seq_e;
endpackage

// >>> core/emu_if.sv
`timescale 1ns/1ps
// Sense, detect and timer signals shared by the sequencer and its helpers
interface emu_if;
   logic [2:0] stim_sel;
   logic vbus_rdy;
   logic vbus_on;
   logic pos_hi;
   logic neg_hi;
   logic pos_low;
   logic hit;
   logic tmr_start;
   logic [2:0] tmr_code;
   logic tmr_exp;
   modport det (input stim_sel, vbus_rdy, vbus_on, pos_hi, neg_hi, pos_low, output hit);
   modport tmr (input tmr_start, tmr_code, output tmr_exp);
   modport ctl (output stim_sel, vbus_rdy, vbus_on, pos_hi, neg_hi, pos_low,
                output tmr_start, tmr_code, input hit, tmr_exp);
endinterface

// >>> core/stim_timer.sv
`timescale 1ns/1ps
module stim_timer import emu_pkg::*; #(
   parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   emu_if.tmr tif
);
   localparam int W = $clog2(MS_CYCLES_P + 1);
   typedef struct packed {
      logic [W-1:0] tick;
      logic [6:0] left;
      logic busy;
      logic exp;
   } tmr_s;
   tmr_s t_r, t_nxt;

   // Millisecond divider restarts on each start so the delay is not short by a tick
   always_comb begin
      t_nxt = t_r;
      t_nxt.exp = 1'b0;
      if (tif.tmr_start) begin
         t_nxt.busy = 1'b1;
         t_nxt.tick = '0;
         t_nxt.left = STIM_DELAY_MS[tif.tmr_code];
      end else if (t_r.busy) begin
         if (t_r.left == 7'h00) begin
            t_nxt.busy = 1'b0;
            t_nxt.exp = 1'b1;
         end else if (t_r.tick == W'(MS_CYCLES_P - 1)) begin
            t_nxt.tick = '0;
            t_nxt.left = t_r.left - 7'h01;
         end else begin
            t_nxt.tick = t_r.tick + 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t_r <= '0;
      end else begin
         t_r <= t_nxt;
      end
   end

   assign tif.tmr_exp = t_r.exp;
endmodule // stim_timer

// >>> core/stim_detect.sv
`timescale 1ns/1ps
module stim_detect import emu_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   emu_if.det dif
);
   typedef struct packed {
      logic hit;
   } det_s;
   det_s d_r, d_nxt;

   // Comparator choice; threshold comparators are not looked at for VBUS codes
   always_comb begin
      d_nxt = d_r;
      case (dif.stim_sel)
         STIM_VBUS_RDY: d_nxt.hit = dif.vbus_rdy;
         STIM_VBUS_ON: d_nxt.hit = dif.vbus_on;
         STIM_POS_HI, STIM_POS_HI2: d_nxt.hit = dif.pos_hi;
         STIM_NEG_HI: d_nxt.hit = dif.neg_hi;
         STIM_WINDOW: d_nxt.hit = !dif.pos_hi && dif.pos_low;
         default: d_nxt.hit = 1'b0; // Unused codes never fire
      endcase
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         d_r <= '0;
      end else begin
         d_r <= d_nxt;
      end
   end

   assign dif.hit = d_r.hit;

   a_window_pos: assert property (@(posedge clk_i) disable iff (rst_i)
      dif.stim_sel == STIM_WINDOW && !dif.neg_hi |=> dif.hit == $past(!dif.pos_hi && dif.pos_low))
      else $error("Window stimulus does not follow positive line");
endmodule // stim_detect

// >>> core/custom_emu.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module custom_emu import emu_pkg::*; #(
   parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic EMU_START_I,
   input wire logic OTHERS_DONE_I,
   input wire logic VBUS_READY_I,
   input wire logic VBUS_PRESENT_I,
   input wire logic POS_ABOVE_TH_I,
   input wire logic NEG_ABOVE_TH_I,
   input wire logic POS_ABOVE_LOW_I,
   output logic PROFILE_EN_O,
   output logic PROFILE_FIRST_O,
   output logic CUSTOM_ACTIVE_O,
   output logic TIMEOUT_RUN_O,
   output logic STIM_HIT_O,
   output logic [1:0] POS_MODE_O,
   output logic [1:0] NEG_MODE_O,
   output logic BRIDGE_O,
   output logic POS_PULLDOWN_O,
   output logic NEG_PULLDOWN_O,
   output logic [3:0] RESP_MAG_O
);
   typedef struct packed {
      logic [7:0] cfg;
      logic en;
      logic [6:0] stim;
      logic [7:0] resp;
      logic pready;
      logic pslverr;
      logic [7:0] prdata;
      seq_e st;
      line_e pos;
      line_e neg;
      logic bridge;
      logic pd_pos;
      logic pd_neg;
      logic [3:0] mag;
      logic active;
      logic timeout_run;
      logic hit;
      logic tstart;
   } top_s;

   top_s s_r, s_nxt;
   logic acc;
   logic wr_done;
   logic mapped;

   emu_if eif ();

   stim_detect u_detect (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .dif(eif)
   );

   stim_timer #(
      .MS_CYCLES_P(MS_CYCLES_P)
   ) u_timer (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .tif(eif)
   );

   // Sense inputs and timer control toward the helpers
   assign eif.stim_sel = s_r.stim[2:0];
   assign eif.vbus_rdy = VBUS_READY_I;
   assign eif.vbus_on = VBUS_PRESENT_I;
   assign eif.pos_hi = POS_ABOVE_TH_I;
   assign eif.neg_hi = NEG_ABOVE_TH_I;
   assign eif.pos_low = POS_ABOVE_LOW_I;
   assign eif.tmr_start = s_r.tstart;
   assign eif.tmr_code = s_r.stim[5:3];

   // Bus decode; one wait state, writes land on the completing edge
   assign mapped = (PADDR_I == CFG_ADDR) || (PADDR_I == STIM_ADDR) || (PADDR_I == RESP_ADDR);
   assign acc = PSEL_I && PENABLE_I && !s_r.pready;
   assign wr_done = PSEL_I && PENABLE_I && s_r.pready && PWRITE_I && mapped;

   // Drive one line, and settle the untouched line's reset pull-down
   function automatic top_s one_line(input top_s s, input logic to_pos, input line_e m,
                                     input logic keep);
      top_s r;
      r = s;
      if (to_pos) begin
         r.pos = m;
         r.pd_pos = 1'b0;
         r.pd_neg = s.pd_neg && keep && (s.neg == LN_NONE);
      end else begin
         r.neg = m;
         r.pd_neg = 1'b0;
         r.pd_pos = s.pd_pos && keep && (s.pos == LN_NONE);
      end
      return r;
   endfunction

   // Carry out the programmed response on the data lines
   function automatic top_s apply_resp(input top_s s);
      top_s r;
      logic keep;
      r = s;
      keep = (s.stim[2:0] == STIM_VBUS_RDY);
      // Magnitude reads as volts, ohms or divider total by response kind
      r.mag = s.resp[7:4];
      case (s.resp[3:0])
         RSP_REMOVE: begin
            r.pos = LN_NONE;
            r.neg = LN_NONE;
            r.bridge = 1'b0;
         end
         RSP_V_POS: r = one_line(r, 1'b1, LN_VOLT, keep);
         RSP_V_NEG: r = one_line(r, 1'b0, LN_VOLT, keep);
         RSP_R_POS: r = one_line(r, 1'b1, LN_RGND, keep);
         RSP_D_POS: r = one_line(r, 1'b1, LN_DIV, keep);
         RSP_R_NEG: r = one_line(r, 1'b0, LN_RGND, keep);
         RSP_D_NEG: r = one_line(r, 1'b0, LN_DIV, keep);
         RSP_V_BOTH, RSP_R_BOTH, RSP_D_BOTH: begin
            r.pos = (s.resp[3:0] == RSP_V_BOTH) ? LN_VOLT :
                    (s.resp[3:0] == RSP_R_BOTH) ? LN_RGND : LN_DIV;
            r.neg = r.pos;
            r.pd_pos = 1'b0;
            r.pd_neg = 1'b0;
         end
         RSP_BRIDGE: begin
            r.bridge = 1'b1;
            r.pd_pos = 1'b0;
            r.pd_neg = 1'b0;
         end
         RSP_PD_A, RSP_PD_B: begin
            // Other stimulus codes change nothing but the magnitude
            if (s.stim[2:0] == STIM_VBUS_ON) begin
               r.pd_pos = 1'b0;
               r.pd_neg = 1'b0;
            end
         end
         default: r = s; // Unused response codes change nothing
      endcase
      return r;
   endfunction

   // Register file, bus answer and profile sequencer
   always_comb begin
      s_nxt = s_r;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      s_nxt.tstart = 1'b0;
      s_nxt.hit = eif.hit;
      // Access phase: prepare read data and the answer for the next edge
      if (acc) begin
         s_nxt.pready = 1'b1;
         s_nxt.pslverr = !mapped;
         if (PADDR_I == CFG_ADDR) begin
            s_nxt.prdata = s_r.cfg;
         end else if (PADDR_I == STIM_ADDR) begin
            s_nxt.prdata = {1'b0, s_r.stim};
         end else if (PADDR_I == RESP_ADDR) begin
            s_nxt.prdata = s_r.resp;
         end else begin
            s_nxt.prdata = 8'h00;
         end
      end
      if (wr_done) begin
         if (PADDR_I == CFG_ADDR) begin
            s_nxt.cfg = PWDATA_I[7:0] & CFG_WMASK;
         end else if (PADDR_I == STIM_ADDR) begin
            s_nxt.stim = PWDATA_I[6:0] & STIM_WMASK[6:0];
         end else begin
            s_nxt.resp[3:0] = PWDATA_I[3:0];
            if (PWDATA_I[7:4] != MAG_RSVD) begin
               s_nxt.resp[7:4] = PWDATA_I[7:4];
            end
         end
      end
      // Sequencer
      case (s_r.st)
         ST_IDLE: begin
            s_nxt.st = ST_IDLE;
         end
         ST_PEND: begin
            if (OTHERS_DONE_I) begin
               s_nxt.st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (eif.hit) begin
               s_nxt.tstart = 1'b1;
               if (s_r.stim[STIM_TYPE_BIT]) begin
                  s_nxt = apply_resp(s_nxt);
                  s_nxt.st = ST_HOLD;
               end else begin
                  s_nxt.st = ST_DELAY;
               end
            end
         end
         ST_DELAY: begin
            if (eif.tmr_exp) begin
               s_nxt = apply_resp(s_nxt);
               s_nxt.st = ST_DONE;
            end
         end
         ST_HOLD: begin
            if (eif.tmr_exp) begin
               if (!eif.hit) begin
                  s_nxt.pos = LN_NONE;
                  s_nxt.neg = LN_NONE;
                  s_nxt.bridge = 1'b0;
               end
               s_nxt.st = ST_DONE;
            end
         end
         ST_DONE: begin
            s_nxt.st = ST_DONE;
         end
         default: s_nxt.st = ST_IDLE;
      endcase
      // A new cycle restarts the sequencer, lines, bridge and magnitude with the reset pull-downs on; the timer is not restarted
      if (EMU_START_I) begin
         s_nxt.pos = LN_NONE;
         s_nxt.neg = LN_NONE;
         s_nxt.bridge = 1'b0;
         s_nxt.pd_pos = 1'b1;
         s_nxt.pd_neg = 1'b1;
         s_nxt.mag = 4'h0;
         s_nxt.tstart = 1'b0;
         if (s_r.cfg[CFG_DIS_BIT]) begin
            s_nxt.st = ST_IDLE;
         end else if (s_r.cfg[CFG_FIRST_BIT]) begin
            s_nxt.st = ST_WAIT;
         end else begin
            s_nxt.st = ST_PEND;
         end
      end
      s_nxt.active = (s_nxt.st != ST_IDLE);
      // Enable kept in its own flop so the output needs no inverter
      s_nxt.en = !s_nxt.cfg[CFG_DIS_BIT];
      // Timeout stays off while the custom profile runs, if asked
      s_nxt.timeout_run = s_nxt.active && !s_nxt.cfg[CFG_TO_DIS_BIT];
   end

   // Only the reset clears the registers
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         s_r <= '0;
         s_r.cfg <= CFG_RST;
         s_r.stim <= STIM_RST;
         s_r.resp <= RESP_RST;
         s_r.st <= ST_IDLE;
         s_r.pos <= LN_NONE;
         s_r.neg <= LN_NONE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign PRDATA_O = {24'h000000, s_r.prdata};
   assign PREADY_O = s_r.pready;
   assign PSLVERR_O = s_r.pslverr;
   assign PROFILE_EN_O = s_r.en;
   assign PROFILE_FIRST_O = s_r.cfg[CFG_FIRST_BIT];
   assign CUSTOM_ACTIVE_O = s_r.active;
   assign TIMEOUT_RUN_O = s_r.timeout_run;
   assign STIM_HIT_O = s_r.hit;
   assign POS_MODE_O = s_r.pos;
   assign NEG_MODE_O = s_r.neg;
   assign BRIDGE_O = s_r.bridge;
   assign POS_PULLDOWN_O = s_r.pd_pos;
   assign NEG_PULLDOWN_O = s_r.pd_neg;
   assign RESP_MAG_O = s_r.mag;

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   sequence s_wait_hit;
      s_r.st == ST_WAIT && eif.hit && !EMU_START_I;
   endsequence

   sequence s_delay_end;
      s_r.st == ST_DELAY && eif.tmr_exp && !EMU_START_I;
   endsequence

   a_rsvd_reads_zero: assert property (
      PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && PADDR_I == CFG_ADDR
      |-> !PRDATA_O[CFG_RSVD_BIT] && !s_r.cfg[CFG_RSVD_BIT])
      else $error("Reserved config bit reads one");

   a_mag_reject: assert property (
      wr_done && PADDR_I == RESP_ADDR && PWDATA_I[7:4] == MAG_RSVD
      |=> $stable(s_r.resp[7:4]))
      else $error("Reserved magnitude code was stored");

   a_mag_accept: assert property (
      wr_done && PADDR_I == RESP_ADDR && PWDATA_I[7:4] != MAG_RSVD
      |=> s_r.resp[7:4] == $past(PWDATA_I[7:4]))
      else $error("Valid magnitude write lost");

   a_order_first: assert property (
      EMU_START_I && !s_r.cfg[CFG_DIS_BIT] && s_r.cfg[CFG_FIRST_BIT]
      |=> s_r.st == ST_WAIT ##1 CUSTOM_ACTIVE_O)
      else $error("First-placed profile did not start");

   a_order_last: assert property (
      EMU_START_I && !s_r.cfg[CFG_DIS_BIT] && !s_r.cfg[CFG_FIRST_BIT]
      |=> s_r.st == ST_PEND)
      else $error("Last-placed profile did not wait its turn");

   a_disable_idle: assert property (
      EMU_START_I && s_r.cfg[CFG_DIS_BIT] |=> s_r.st == ST_IDLE && !CUSTOM_ACTIVE_O)
      else $error("Disabled profile was used");

   a_timeout_off: assert property (
      CUSTOM_ACTIVE_O && s_r.cfg[CFG_TO_DIS_BIT] |-> !TIMEOUT_RUN_O)
      else $error("Timeout runs though disabled");

   a_type1_apply: assert property (
      s_wait_hit ##0 s_r.stim[STIM_TYPE_BIT] && s_r.resp[3:0] == RSP_D_BOTH
      |=> s_r.st == ST_HOLD && POS_MODE_O == LN_DIV && NEG_MODE_O == LN_DIV)
      else $error("Held response not applied at once");

   a_type0_wait: assert property (
      s_wait_hit ##0 !s_r.stim[STIM_TYPE_BIT]
      |=> s_r.st == ST_DELAY && $stable(POS_MODE_O) && $stable(NEG_MODE_O))
      else $error("Delayed response applied too early");

   a_mag_out: assert property (
      s_delay_end |=> RESP_MAG_O == $past(s_r.resp[7:4]) && s_r.st == ST_DONE)
      else $error("Response magnitude not driven");

   a_pd_drop: assert property (
      s_delay_end ##0 (s_r.resp[3:0] == RSP_PD_A || s_r.resp[3:0] == RSP_PD_B)
      && s_r.stim[2:0] == STIM_VBUS_ON
      |=> !POS_PULLDOWN_O && !NEG_PULLDOWN_O)
      else $error("Reset pull-downs kept for VBUS present");

   a_vbus_go: assert property (
      s_r.st == ST_WAIT && s_r.stim[2:0] == STIM_VBUS_RDY && eif.hit && !EMU_START_I
      |=> s_r.st != ST_WAIT)
      else $error("VBUS ready stimulus not taken");
endmodule // custom_emu

// >>> bench/port_device.sv
`timescale 1ns/1ps
// Attached portable device: shows the chosen stimulus on the comparator lines
module port_device import emu_pkg::*; (
   input wire logic clk_i,
   input wire logic [2:0] kind_i,
   input wire logic on_i,
   input wire logic noise_i,
   output logic vbus_rdy_o,
   output logic vbus_on_o,
   output logic pos_th_o,
   output logic neg_th_o,
   output logic pos_low_o
);
   logic vb;
   // VBUS stimuli leave the data lines floating, so they chatter
   assign vb = kind_i == STIM_VBUS_RDY || kind_i == STIM_VBUS_ON;
   // Comparator levels change one cycle after a request, like a real settle
   always_ff @(posedge clk_i) begin
      vbus_rdy_o <= on_i && kind_i == STIM_VBUS_RDY;
      vbus_on_o <= on_i && kind_i == STIM_VBUS_ON;
      pos_th_o <= vb ? noise_i : on_i && (kind_i == STIM_POS_HI || kind_i == STIM_POS_HI2);
      neg_th_o <= vb ? ~noise_i : on_i && kind_i == STIM_NEG_HI;
      // Window case sits above the fixed floor but under the threshold
      pos_low_o <= vb ? noise_i : on_i && kind_i != STIM_NEG_HI;
   end
endmodule // port_device

// >>> bench/tb_custom_emu.sv
`timescale 1ns/1ps
module tb_custom_emu import emu_pkg::*; ();
   localparam int MS = 10;
   localparam logic [3:0] RT [0:7] = '{RSP_REMOVE, RSP_V_POS, RSP_V_NEG, RSP_R_POS,
                                       RSP_D_POS, RSP_D_NEG, RSP_R_BOTH, RSP_V_BOTH};
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, start = 0, odone = 0, on = 0;
   logic [2:0] kind = 3'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, prdata, seed = 32'h311d, nz = 32'h311d;
   logic er, pready, pslverr, p_en, p_first, active, to_run, hit, bridge, ppd, npd;
   logic vr, vp, pth, nth, plow;
   logic [1:0] pmode, nmode;
   logic [3:0] mag;
   logic [7:0] v;
   int num_errors = 0, checks = 0;

   custom_emu #(.MS_CYCLES_P(MS)) u_custom_emu (.CLK_I(clk), .SYS_RST_I(rst),
      .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .EMU_START_I(start),
      .OTHERS_DONE_I(odone), .VBUS_READY_I(vr), .VBUS_PRESENT_I(vp), .POS_ABOVE_TH_I(pth),
      .NEG_ABOVE_TH_I(nth), .POS_ABOVE_LOW_I(plow), .PROFILE_EN_O(p_en),
      .PROFILE_FIRST_O(p_first), .CUSTOM_ACTIVE_O(active), .TIMEOUT_RUN_O(to_run),
      .STIM_HIT_O(hit), .POS_MODE_O(pmode), .NEG_MODE_O(nmode), .BRIDGE_O(bridge),
      .POS_PULLDOWN_O(ppd), .NEG_PULLDOWN_O(npd), .RESP_MAG_O(mag));
   port_device u_port_device (.clk_i(clk), .kind_i(kind), .on_i(on), .noise_i(nz[0]),
      .vbus_rdy_o(vr), .vbus_on_o(vp), .pos_th_o(pth), .neg_th_o(nth), .pos_low_o(plow));

   // Free-running clock, 5 ns period
   initial forever #2.5 clk = ~clk;
   // Separate noise stream so the main sequence stays repeatable
   always @(posedge clk) nz <= lfsr(nz);

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected connection of one line for a response code
   function automatic logic [1:0] emode(input logic [3:0] r, input logic n);
      if (r == RSP_V_BOTH || r == (n ? RSP_V_NEG : RSP_V_POS)) return LN_VOLT;
      if (r == RSP_R_BOTH || r == (n ? RSP_R_NEG : RSP_R_POS)) return LN_RGND;
      if (r == RSP_D_BOTH || r == (n ? RSP_D_NEG : RSP_D_POS)) return LN_DIV;
      return LN_NONE;
   endfunction
   // Expected reset pull-down on one line
   function automatic logic epd(input logic [2:0] s, input logic [3:0] r, input logic [1:0] l);
      if (r == RSP_PD_A || r == RSP_PD_B || r == RSP_REMOVE)
         return s != STIM_VBUS_ON || r == RSP_REMOVE;
      if (l != LN_NONE) return 1'b0;
      return s == STIM_VBUS_RDY;
   endfunction

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   // One APB transfer; waits for the slave, never assumes a latency
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      pen <= 0;
   endtask
   task automatic rdchk(input string s, input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 32'h0);
      chk(s, e, rd);
   endtask
   task automatic results;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // One emulation cycle: program, start, show stimulus, watch the response
   task automatic run(input logic [2:0] st, input logic ty, input logic [2:0] dl,
                      input logic [3:0] rs, input logic lst, input logic tod);
      logic [3:0] m;
      logic [1:0] ep, en;
      int c, t;
      m = 4'(seed % 15);
      seed = lfsr(seed);
      ep = emode(rs, 1'b0);
      en = emode(rs, 1'b1);
      t = int'(STIM_DELAY_MS[dl]) * MS;
      // Lines quiet for the new stimulus long before the cycle starts
      kind <= st;
      apb(1, CFG_ADDR, {26'h0, tod, 2'h0, ~lst, 2'h0});
      apb(1, STIM_ADDR, {25'h0, ty, dl, st});
      apb(1, RESP_ADDR, {24'h0, m, rs});
      @(posedge clk) start <= 1;
      @(posedge clk) start <= 0;
      @(posedge clk);
      chk("pulldown", 2'b11, {ppd, npd});
      on <= 1;
      if (lst) begin
         repeat (20) @(posedge clk);
         chk("order", 4'h0, {pmode, nmode});
         odone <= 1;
         @(posedge clk) odone <= 0;
      end
      c = 0;
      while ({pmode, nmode, bridge} !== {ep, en, rs == RSP_BRIDGE} && c < t + 20) begin
         @(posedge clk);
         c++;
      end
      chk("delay", 1, ty ? c <= 8 : (c >= t && c <= t + 12));
      repeat (8) @(posedge clk);
      chk("hit", 1, hit);
      chk("timeout", !tod, to_run);
      chk("mag", m, mag);
      if (rs != RSP_BRIDGE) chk("pd", {epd(st, rs, ep), epd(st, rs, en)}, {ppd, npd});
      on <= 0;
      if (ty) begin
         c = 0;
         while ({pmode, nmode} !== 4'h0 && c < t + 20) begin
            @(posedge clk);
            c++;
         end
         chk("remove", 4'h0, {pmode, nmode});
      end
      $display("test run %0d done", st);
   endtask

   // Watchdog sized well beyond the longest delay loop
   initial begin
      #100000;
      num_errors++;
      results;
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 0;
      rdchk("cfg_rst", CFG_ADDR, {24'h0, CFG_RST});
      rdchk("stim_rst", STIM_ADDR, 32'h0);
      rdchk("resp_rst", RESP_ADDR, {24'h0, RESP_RST});
      chk("en_rst", 0, p_en);
      apb(0, 12'h10c, 32'h0);
      chk("slverr", 1, er);
      for (int i = 0; i < 4; i++) begin
         v = seed[7:0] & 8'hfd;
         seed = lfsr(seed);
         apb(1, CFG_ADDR, {24'h0, v});
         rdchk("cfg", CFG_ADDR, {24'h0, v & CFG_WMASK});
         chk("en", !v[0], p_en);
         chk("first", v[2], p_first);
      end
      v = seed[7:0];
      apb(1, STIM_ADDR, {24'h0, v});
      rdchk("stim", STIM_ADDR, {24'h0, v & STIM_WMASK});
      apb(1, RESP_ADDR, {24'h0, 4'h3, v[3:0]});
      apb(1, RESP_ADDR, {24'h0, MAG_RSVD, ~v[3:0]});
      rdchk("resp", RESP_ADDR, {24'h0, 4'h3, ~v[3:0]});
      $display("test registers done");
      for (int i = 0; i < 8; i++) run(STIM_POS_HI, 0, 3'(i), RT[i], 0, 0);
      run(STIM_VBUS_RDY, 0, 3'h0, RSP_R_NEG, 0, 1);
      run(STIM_VBUS_ON, 1, 3'h2, RSP_D_BOTH, 0, 0);
      run(STIM_NEG_HI, 0, 3'h2, RSP_V_BOTH, 1, 0);
      run(STIM_WINDOW, 0, 3'h0, RSP_PD_A, 0, 0);
      run(STIM_POS_HI2, 0, 3'h0, RSP_BRIDGE, 1, 0);
      run(STIM_VBUS_ON, 0, 3'h0, RSP_PD_B, 0, 0);
      // Timeout back on and profile disabled before the last cycle
      apb(1, CFG_ADDR, 32'h1);
      @(posedge clk) start <= 1;
      @(posedge clk) start <= 0;
      repeat (3) @(posedge clk);
      chk("disabled", 0, active);
      $display("test disable done");
      results;
   end
endmodule // tb_custom_emu
